// *** logic/trpwm_edge_sync.sv ***
`default_nettype none
module trpwm_edge_sync (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic pin_i,
   input wire logic [1:0] edge_sel_i,
   output logic edge_o
);
   logic sync1;
   logic sync2;
   logic prev;
   wire rise = sync2 & ~prev;
   wire fall = ~sync2 & prev;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         prev <= 1'b0;
      end
      else
      begin
         sync1 <= pin_i;
         sync2 <= sync1;
         prev <= sync2;
      end
   end

   assign edge_o = (rise & edge_sel_i[trpwm_pkg::EDGE_RISE_BIT])
                 | (fall & edge_sel_i[trpwm_pkg::EDGE_FALL_BIT]);
endmodule
`default_nettype wire

// *** logic/trpwm_timer.sv ***
// Decided for this implementation: the placing of the registers and the Wishbone slave port.
`default_nettype none
module trpwm_timer #(
   parameter int N_AUX = 3
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic trigger_in_i,
   input wire logic event_in_i,
   output logic period_square_out_o,
   output logic [N_AUX-1:0] aux_pwm_out_o,
   output logic period_match_irq_o,
   output logic [N_AUX-1:0] aux_match_irq_o
);
   localparam int CW = trpwm_pkg::CNT_W;
   localparam int PW = trpwm_pkg::PRESC_W;

   // ==========================================================
   // helpers
   function automatic logic [7:0] ccr_adr(input int m);
      ccr_adr = trpwm_pkg::ADR_CCR0 + 8'(m * 4);
   endfunction

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] dat, input logic [3:0] sel);
      merge16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
   endfunction

   // ==========================================================
   // registers and state
   logic run_enable;
   logic [2:0] clock_prescale_select;
   logic count_source_select;
   logic [2:0] operating_mode_field;
   logic [7:0] output_control;
   logic [3:0] edge_select_control;
   logic [CW-1:0] ccr [0:N_AUX];
   logic [CW-1:0] shadow [0:N_AUX];
   logic [CW-1:0] next_shadow [0:N_AUX];
   logic [CW-1:0] cnt;
   logic [CW-1:0] next_cnt;
   logic [PW-1:0] presc;
   logic armed;
   logic sq;
   logic next_sq;
   logic ack;
   logic [15:0] rd16;
   trpwm_pkg::trpwm_state_e state;
   trpwm_pkg::trpwm_state_e next_state;

   // ==========================================================
   // wishbone slave
   wire req = wb_cyc_i & wb_stb_i;
   // write lands on the edge where the master samples ack
   wire wr = req & ack & wb_we_i;
   wire ack_rise = req & ~ack;
   wire wr_ctl0 = wr & (wb_adr_i == trpwm_pkg::ADR_CTL0) & wb_sel_i[0];
   wire wr_ctl1 = wr & (wb_adr_i == trpwm_pkg::ADR_CTL1) & wb_sel_i[0];
   wire wr_outc = wr & (wb_adr_i == trpwm_pkg::ADR_OUTC) & wb_sel_i[0];
   wire wr_edge = wr & (wb_adr_i == trpwm_pkg::ADR_EDGE) & wb_sel_i[0];
   logic [N_AUX:0] ccr_wr;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ack <= 1'b0;
      else
         ack <= ack_rise;
   end
   assign wb_ack_o = ack;

   always_comb
   begin
      rd16 = 16'h0000;
      if (wb_adr_i == trpwm_pkg::ADR_CTL0)
         rd16 = {8'h00, run_enable, 4'h0, clock_prescale_select};
      else if (wb_adr_i == trpwm_pkg::ADR_CTL1)
         rd16 = {10'h000, count_source_select, 2'h0, operating_mode_field};
      else if (wb_adr_i == trpwm_pkg::ADR_OUTC)
         rd16 = {8'h00, output_control};
      else if (wb_adr_i == trpwm_pkg::ADR_EDGE)
         rd16 = {12'h000, edge_select_control};
      else if (wb_adr_i == trpwm_pkg::ADR_CNT)
         rd16 = cnt;
      for (int m = 0; m <= N_AUX; m++)
         if (wb_adr_i == ccr_adr(m))
            rd16 = ccr[m];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wb_dat_o <= 32'h00000000;
      else if (ack_rise)
         wb_dat_o <= {16'h0000, rd16};
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         run_enable <= 1'b0;
         clock_prescale_select <= 3'h0;
         count_source_select <= 1'b0;
         operating_mode_field <= 3'h0;
         output_control <= trpwm_pkg::CTL_RST;
         edge_select_control <= 4'h0;
      end
      else
      begin
         if (wr_ctl0)
         begin
            run_enable <= wb_dat_i[trpwm_pkg::CTL0_RUN_BIT];
            clock_prescale_select <= wb_dat_i[trpwm_pkg::CTL0_CKS_LSB +: 3];
         end
         if (wr_ctl1)
         begin
            count_source_select <= wb_dat_i[trpwm_pkg::CTL1_EEE_BIT];
            operating_mode_field <= wb_dat_i[trpwm_pkg::CTL1_MODE_LSB +: 3];
         end
         if (wr_outc)
            output_control <= wb_dat_i[7:0];
         if (wr_edge)
            edge_select_control <= wb_dat_i[3:0];
      end
   end

   // ==========================================================
   // compare registers and shadow buffers
   genvar g;
   generate
      for (g = 0; g <= N_AUX; g++)
      begin : g_ccr
         assign ccr_wr[g] = wr & (wb_adr_i == ccr_adr(g));
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               ccr[g] <= trpwm_pkg::CCR_RST;
               shadow[g] <= trpwm_pkg::CCR_RST;
            end
            else
            begin
               if (ccr_wr[g])
                  ccr[g] <= merge16(ccr[g], wb_dat_i, wb_sel_i);
               shadow[g] <= next_shadow[g];
            end
         end
      end
   endgenerate

   // ==========================================================
   // trigger, event and count clock
   logic trig_edge;
   logic evt_edge;

   trpwm_edge_sync u_trig (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(trigger_in_i),
      .edge_sel_i(edge_select_control[trpwm_pkg::EDGE_ETS_LSB +: 2]),
      .edge_o(trig_edge)
   );

   trpwm_edge_sync u_evt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(event_in_i),
      .edge_sel_i(edge_select_control[trpwm_pkg::EDGE_EES_LSB +: 2]),
      .edge_o(evt_edge)
   );

   // software trigger acts on a written 1 only
   wire sw_trig = wr_ctl1 & wb_dat_i[trpwm_pkg::CTL1_EST_BIT];
   wire trig = trig_edge | sw_trig;
   // only the pwm mode code runs
   wire active = run_enable & (operating_mode_field == trpwm_pkg::MODE_PWM);

   // prescaler divides by 2 to the power of the select field
   wire [PW-1:0] presc_mask = PW'((trpwm_pkg::PRESC_ONE << clock_prescale_select) - trpwm_pkg::PRESC_ONE);
   wire presc_tick = (presc & presc_mask) == presc_mask;
   wire tick = count_source_select ? evt_edge : presc_tick;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         presc <= '0;
      else
         presc <= presc + trpwm_pkg::PRESC_ONE;
   end

   // ==========================================================
   // counter control
   wire in_run = state == trpwm_pkg::ST_RUN;
   wire in_wait = state == trpwm_pkg::ST_WAIT;
   wire start = active & in_wait & trig;
   wire retrig = active & in_run & trig;
   // clear on the step after matching the period buffer
   wire period_clear = active & in_run & ~trig & tick & (cnt == shadow[0]);
   wire cnt_step = start | retrig | (active & in_run & tick);
   // reload gated by compare 1 write, always on start
   wire load_shadow = start | (period_clear & armed);

   always_comb
   begin
      next_state = state;
      unique case (state)
         trpwm_pkg::ST_IDLE:
            if (active)
               next_state = trpwm_pkg::ST_WAIT;
         trpwm_pkg::ST_WAIT:
            if (!active)
               next_state = trpwm_pkg::ST_IDLE;
            else if (trig)
               next_state = trpwm_pkg::ST_RUN;
         trpwm_pkg::ST_RUN:
            if (!active)
               next_state = trpwm_pkg::ST_IDLE;
         default:
            next_state = trpwm_pkg::ST_IDLE;
      endcase
   end

   always_comb
   begin
      next_cnt = cnt;
      if (!active)
         next_cnt = trpwm_pkg::CNT_MAX;
      else if (start | retrig)
         next_cnt = trpwm_pkg::CNT_ZERO;
      // period of compare 0 plus one
      else if (period_clear)
         next_cnt = trpwm_pkg::CNT_ZERO;
      else if (in_run & tick)
         next_cnt = cnt + trpwm_pkg::CNT_ONE;
   end

   always_comb
   begin
      for (int m = 0; m <= N_AUX; m++)
         next_shadow[m] = load_shadow ? ccr[m] : shadow[m];
   end

   assign next_sq = active & (sq ^ (start | retrig | period_clear));

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state <= trpwm_pkg::ST_IDLE;
         cnt <= trpwm_pkg::CNT_MAX;
         sq <= 1'b0;
         armed <= 1'b0;
      end
      else
      begin
         state <= next_state;
         cnt <= next_cnt;
         sq <= next_sq;
         // compare 1 write arms; a write in the reload cycle wins
         if (ccr_wr[1])
            armed <= 1'b1;
         else if (load_shadow)
            armed <= 1'b0;
      end
   end

   // ==========================================================
   // outputs
   wire oe0 = output_control[trpwm_pkg::OUT_OE_OFS];
   wire ol0 = output_control[trpwm_pkg::OUT_OL_OFS];
   wire next_running = next_state == trpwm_pkg::ST_RUN;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         period_square_out_o <= 1'b0;
         period_match_irq_o <= 1'b0;
      end
      else
      begin
         period_square_out_o <= oe0 ? next_sq : ol0;
         period_match_irq_o <= period_clear;
      end
   end

   generate
      for (g = 1; g <= N_AUX; g++)
      begin : g_aux
         wire oe = output_control[g * trpwm_pkg::OUT_STRIDE + trpwm_pkg::OUT_OE_OFS];
         wire pol = output_control[g * trpwm_pkg::OUT_STRIDE + trpwm_pkg::OUT_OL_OFS];
         wire on = next_running & (next_cnt < next_shadow[g]);
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               aux_pwm_out_o[g-1] <= 1'b0;
               aux_match_irq_o[g-1] <= 1'b0;
            end
            else
            begin
               aux_pwm_out_o[g-1] <= oe ? (on ^ pol) : pol;
               aux_match_irq_o[g-1] <= cnt_step & (next_cnt == next_shadow[g]);
            end
         end
      end
   endgenerate

   // ==========================================================
   // checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   mode_gate_a: assert property (!active |=> state == trpwm_pkg::ST_IDLE && cnt == trpwm_pkg::CNT_MAX)
      else $error("not idle while mode or run is off");
   first_start_a: assert property (start |=> in_run && cnt == trpwm_pkg::CNT_ZERO && $past(cnt) == trpwm_pkg::CNT_MAX)
      else $error("first trigger did not start from zero");
   retrig_clear_a: assert property (retrig |=> cnt == trpwm_pkg::CNT_ZERO && sq != $past(sq))
      else $error("retrigger did not clear and invert");
   period_irq_a: assert property (period_clear |=> period_match_irq_o && cnt == trpwm_pkg::CNT_ZERO)
      else $error("period match pulse or clear missing");
   aux_irq_a: assert property (aux_match_irq_o[0] |-> cnt == shadow[1])
      else $error("aux match pulse without equal count");
   aux_never_a: assert property (aux_match_irq_o[0] && in_run |-> shadow[1] <= shadow[0])
      else $error("aux match with compare above period");
   reload_a: assert property (period_clear && armed && !ccr_wr[0] |=> shadow[0] == $past(ccr[0]) && armed == $past(ccr_wr[1]))
      else $error("shadow reload missed");
   no_reload_a: assert property (period_clear && !armed && !start |=> shadow[2] == $past(shadow[2]))
      else $error("shadow reloaded without compare 1 write");
   sw_trig_a: assert property (sw_trig && active && in_wait |=> in_run)
      else $error("software trigger ignored");
   idle_level_a: assert property (!oe0 ##1 !$past(wr_outc) |-> period_square_out_o == ol0)
      else $error("output 0 not at idle level");
   aux_high_a: assert property (retrig && shadow[1] != trpwm_pkg::CNT_ZERO && output_control[3:2] == 2'b01
      && !ccr_wr[1] && !wr_outc |=> aux_pwm_out_o[0])
      else $error("aux not forced active on retrigger");

   retrig_c: cover property (retrig);
   period_clear_c: cover property (period_clear && armed);
   aux_irq_c: cover property (aux_match_irq_o[2]);
   event_count_c: cover property (count_source_select && in_run && tick);
endmodule
`default_nettype wire

// *** pkg/trpwm_pkg.sv ***
`default_nettype none
package trpwm_pkg;
   // ==========================================================
   // register map, byte addresses
   localparam logic [7:0] ADR_CTL0 = 8'h00;
   localparam logic [7:0] ADR_CTL1 = 8'h04;
   localparam logic [7:0] ADR_OUTC = 8'h08;
   localparam logic [7:0] ADR_EDGE = 8'h0C;
   localparam logic [7:0] ADR_CNT = 8'h10;
   localparam logic [7:0] ADR_CCR0 = 8'h14;
   localparam logic [7:0] ADR_STEP = 8'h04;
   // ==========================================================
   // field positions
   localparam int CTL0_RUN_BIT = 7;
   localparam int CTL0_CKS_LSB = 0;
   localparam int CTL1_EST_BIT = 6;
   localparam int CTL1_EEE_BIT = 5;
   localparam int CTL1_MODE_LSB = 0;
   localparam int OUT_OE_OFS = 0;
   localparam int OUT_OL_OFS = 1;
   localparam int OUT_STRIDE = 2;
   localparam int EDGE_ETS_LSB = 0;
   localparam int EDGE_EES_LSB = 2;
   localparam int EDGE_RISE_BIT = 0;
   localparam int EDGE_FALL_BIT = 1;
   // ==========================================================
   // values
   localparam int CNT_W = 16;
   localparam int PRESC_W = 7;
   localparam logic [2:0] MODE_PWM = 3'h2;
   localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam logic [CNT_W-1:0] CCR_RST = 16'h0000;
   localparam logic [7:0] CTL_RST = 8'h00;
   localparam logic [PRESC_W-1:0] PRESC_ONE = 7'h01;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WAIT = 3'b010,
      ST_RUN = 3'b100
   } trpwm_state_e;
endpackage
`default_nettype wire

// *** test/tb_triggered_pwm_timer.sv ***
`default_nettype none
module tb_triggered_pwm_timer;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i, rst_i, cyc, stb, we, ack, trig, evt, sq, pirq;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] di, dq, q;
   logic [2:0] aux, airq;
   int error_cnt, tests_run, pi, sc;
   int hi[3];
   int ai[3];
   trpwm_timer dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(di), .wb_dat_o(dq), .wb_ack_o(ack),
      .trigger_in_i(trig), .event_in_i(evt), .period_square_out_o(sq), .aux_pwm_out_o(aux),
      .period_match_irq_o(pirq), .aux_match_irq_o(airq));
   trpwm_pin_drv drv_u (.clk_i(clk_i), .trig_o(trig), .evt_o(evt));
   initial
   begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   // ==========================================
   // shared tasks
   task automatic end_sim;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      tests_run++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // one classic cycle; a leading edge keeps cyc low between requests
   task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'h3;
      di <= {16'h0000, d};
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      q = dq;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (n >= 20)
      begin
         error_cnt++;
         end_sim;
      end
   endtask
   // sampled right after each edge, so values are those of the closing cycle
   task automatic watch(input int n);
      logic s;
      hi = '{0, 0, 0};
      ai = '{0, 0, 0};
      pi = 0;
      sc = 0;
      s = sq;
      repeat (n)
      begin
         @(posedge clk_i);
         for (int k = 0; k < 3; k++)
         begin
            hi[k] += int'(aux[k]);
            ai[k] += int'(airq[k]);
         end
         pi += int'(pirq);
         sc += int'(sq !== s);
         s = sq;
      end
   endtask
   task automatic waitp;
      int n;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (pirq !== 1'b1 && n < 40);
      if (n >= 40)
      begin
         error_cnt++;
         end_sim;
      end
   endtask
   // ==========================================
   // scenarios
   task automatic s_reset;
      wb(0, 8'h10, 16'h0000);
      chk(q, 32'h0000FFFF, "count at reset");
      wb(0, 8'h00, 16'h0000);
      chk(q, 32'h00000000, "control0 at reset");
      wb(0, 8'hF0, 16'h0000);
      chk(q, 32'h00000000, "unmapped read");
   endtask
   task automatic s_pwm;
      wb(1, 8'h14, 16'h0009);
      wb(1, 8'h1C, 16'h0000);
      wb(1, 8'h20, 16'h000C);
      wb(1, 8'h18, 16'h0003);
      wb(1, 8'h08, 16'h0055);
      wb(1, 8'h04, 16'h0002);
      wb(1, 8'h00, 16'h0080);
      wb(0, 8'h10, 16'h0000);
      chk(q, 32'h0000FFFF, "waiting count");
      wb(1, 8'h04, 16'h0042);
      watch(40);
      chk(hi[0], 12, "aux1 width");
      chk(hi[1], 0, "aux2 zero duty");
      chk(hi[2], 40, "aux3 above period");
      chk(ai[0], 4, "aux1 match count");
      chk(ai[1], 4, "aux2 zero compare match");
      chk(ai[2], 0, "aux3 no match");
      chk(pi, 3, "period matches");
      chk(sc, 4, "square toggles");
   endtask
   task automatic s_retrig;
      logic s;
      int n;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (airq[0] !== 1'b1 && n < 40);
      if (n >= 40)
      begin
         error_cnt++;
         end_sim;
      end
      s = sq;
      wb(1, 8'h04, 16'h0042);
      watch(4);
      chk(sq, !s, "square level after retrigger");
      chk(hi[0], 3, "aux1 forced on retrigger");
      chk(sc, 1, "square inverted");
      chk(pi, 0, "no period match");
   endtask
   task automatic s_shadow;
      wb(1, 8'h1C, 16'h0005);
      waitp;
      watch(10);
      chk(hi[1], 0, "aux2 not yet updated");
      wb(1, 8'h18, 16'h0006);
      waitp;
      waitp;
      watch(10);
      chk(hi[0], 6, "aux1 new width");
      chk(hi[1], 5, "aux2 updated");
      chk(pi, 1, "period length");
   endtask
   task automatic s_pol;
      wb(1, 8'h08, 16'h009E);
      waitp;
      watch(10);
      chk(hi[0], 4, "aux1 active low");
      chk(hi[2], 10, "aux3 disabled level");
      chk(sc, 0, "square disabled");
      chk(sq, 1'b1, "square idle level");
   endtask
   task automatic s_stop;
      wb(1, 8'h00, 16'h0000);
      wb(0, 8'h10, 16'h0000);
      chk(q, 32'h0000FFFF, "stopped count");
      watch(12);
      chk(pi + ai[0], 0, "no matches when stopped");
   endtask
   task automatic s_mode;
      wb(1, 8'h04, 16'h0001);
      wb(1, 8'h00, 16'h0080);
      wb(1, 8'h04, 16'h0041);
      wb(0, 8'h10, 16'h0000);
      chk(q, 32'h0000FFFF, "other mode ignores trigger");
      wb(1, 8'h00, 16'h0000);
   endtask
   task automatic s_ext;
      wb(1, 8'h0C, 16'h0006);
      wb(1, 8'h04, 16'h0022);
      wb(1, 8'h00, 16'h0080);
      drv_u.flip(0, 6);
      wb(0, 8'h10, 16'h0000);
      chk(q, 32'h0000FFFF, "rising trigger ignored");
      drv_u.flip(0, 6);
      wb(0, 8'h10, 16'h0000);
      chk(q, 32'h00000000, "falling trigger starts");
      for (int k = 0; k < 8; k++)
      begin
         drv_u.flip(1, 4);
      end
      wb(0, 8'h10, 16'h0000);
      chk(q, 32'h00000004, "event edges counted");
   endtask
   initial
   begin
      error_cnt = 0;
      tests_run = 0;
      rst_i = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      sel = 4'h0;
      di = 32'h00000000;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      s_reset;
      s_pwm;
      s_retrig;
      s_shadow;
      s_pol;
      s_stop;
      s_mode;
      s_ext;
      end_sim;
   end
endmodule
`default_nettype wire

// *** test/trpwm_pin_drv.sv ***
`default_nettype none
module trpwm_pin_drv (
   input wire logic clk_i,
   output logic trig_o,
   output logic evt_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      trig_o = 1'b0;
      evt_o = 1'b0;
   end
   // ==========================================
   // pin stimulus
   // one level change, held for hold cycles
   // hold below 3 would race the input synchroniser
   task automatic flip(input bit ev, input int hold);
      @(posedge clk_i);
      if (ev)
         evt_o <= ~evt_o;
      else
         trig_o <= ~trig_o;
      repeat (hold) @(posedge clk_i);
   endtask
endmodule
`default_nettype wire
